// *** design/rib_bank.v ***
// What this block does
// R1: Pull data low to acknowledge accepted bytes
// R2: Data left high in ack slot means refusal
// R3: Disabled bits store and read back, unused
// R4: Read-only bits ignore writes entirely
// R5: Enable bit shared by both setpoint registers
// R6: Enable bit low forces shutdown always
// R7: Enable bit high: run follows enable pin
// R8: Low six setpoint bits drive reference code
// R9: Vendor code bits fixed, readable, ignore writes
// R10: Software mode: high setpoint applied on trigger
// R11: Pin mode: select pin picks setpoint register
// R12: Override field selects PFM policy
// R13: High permit bit gates PFM on high
// R14: Low permit bit is storage only
// R15: Reset values follow factory option strap
// R16: Answer address 1001 plus option bits
// R17: Index kept across repeated start for reads
// R18: Trigger bit self-clears when transition ends
// R19: Reserved bits read reset value, ignore writes; the mode control reserved bit reads 1, not the 0 of its reset value 8'h90
`include "rib_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rib_bank (
   input  wire       clk_sys,
   input  wire       srst,
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe,
   input  wire       en_pin,
   input  wire       setpoint_select_pin,
   input  wire [1:0] option_sel,
   input  wire [2:0] addr_option,
   input  wire       power_good,
   input  wire       xfer_done,
   output reg        conv_run,
   output reg  [5:0] dac_code,
   output reg        pfm_allow,
   output reg        discharge_en,
   output reg  [2:0] slew_code,
   output reg        xfer_start
);

   ////////////////////////////////////////////////////////////////////////
   localparam ST_IDLE = 3'd0;
   localparam ST_RX   = 3'd1;
   localparam ST_ACKO = 3'd2;
   localparam ST_TX   = 3'd3;
   localparam ST_ACKI = 3'd4;
   localparam [7:0] MODE_RST = `RIB_MODE_RST;
   localparam K_ADDR  = 2'd0;
   localparam K_REG   = 2'd1;
   localparam K_DATA  = 2'd2;

   reg  [2:0] state_r;
   reg  [1:0] kind_r;
   reg  [3:0] cnt_r;
   reg  [7:0] shift_r;
   reg        rw_r;
   reg        nack_r;
   reg  [7:0] idx_r;
   reg        en_bit_r;
   reg  [5:0] low_dac_r;
   reg  [5:0] high_dac_r;
   reg  [5:0] sw_dac_r;
   reg        hw_sel_r;
   reg  [1:0] mode_ovr_r;
   reg        hi_permit_r;
   reg        lo_permit_r;
   reg        go_r;
   reg        dis_r;
   reg  [2:0] slew_r;
   wire       scl_rise;
   wire       scl_fall;
   wire       bus_start;
   wire       bus_stop;
   wire       pol_run;
   wire [5:0] pol_code;
   wire       pol_pfm;
   wire       wr_stb;
   wire       addr_hit;
   reg  [7:0] rst_low;
   reg  [7:0] rst_high;
   reg  [7:0] rst_xfer;

   ////////////////////////////////////////////////////////////////////////
   // Readback of one register; reserved and vendor bits are constants
   function [7:0] rib_read;
      input [7:0]  idx;
      input [31:0] img;
      begin
         case (idx)
            `RIB_IDX_LOW:  rib_read = img[7:0];
            `RIB_IDX_HIGH: rib_read = img[15:8];
            `RIB_IDX_MODE: rib_read = img[23:16];
            `RIB_IDX_XFER: rib_read = img[31:24];
            default:       rib_read = 8'h00;
         endcase
      end
   endfunction

   // Image order: transition, mode, high, low
   wire [31:0] reg_img = {go_r, dis_r, power_good, // R4
                          `RIB_XC_RSV_VAL, slew_r, // R19
                          `RIB_VENDOR_ID, `RIB_MC_RSV_VAL, // R9 R19
                          hw_sel_r, mode_ovr_r,
                          hi_permit_r, lo_permit_r, // R3
                          en_bit_r, `RIB_SP_RSV_VAL, high_dac_r, // R5 R19
                          en_bit_r, `RIB_SP_RSV_VAL, low_dac_r}; // R5 R19
   wire [7:0]  rd_cur  = rib_read(idx_r, reg_img);
   wire [7:0]  rd_nxt  = rib_read(idx_r + 8'h01, reg_img);

   ////////////////////////////////////////////////////////////////////////
   rib_cond u_cond (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .bus_start (bus_start),
      .bus_stop  (bus_stop)
   );
   rib_policy u_policy (
      .en_bit    (en_bit_r),
      .en_pin    (en_pin),
      .hw_sel    (hw_sel_r),
      .sel_pin   (setpoint_select_pin),
      .mode_ovr  (mode_ovr_r),
      .hi_permit (hi_permit_r),
      .low_code  (low_dac_r),
      .sw_code   (sw_dac_r),
      .high_code (high_dac_r),
      .run       (pol_run),
      .code      (pol_code),
      .pfm       (pol_pfm)
   );

   ////////////////////////////////////////////////////////////////////////
   // Factory option picks the reset image
   always @* begin
      case (option_sel)
         `RIB_OPT_00: {rst_low, rst_high, rst_xfer} =
            {`RIB_LOW_RST_00, `RIB_HIGH_RST_00, `RIB_XFER_RST_0002};
         `RIB_OPT_02: {rst_low, rst_high, rst_xfer} =
            {`RIB_LOW_RST_02, `RIB_HIGH_RST_02, `RIB_XFER_RST_0002};
         `RIB_OPT_03: {rst_low, rst_high, rst_xfer} =
            {`RIB_LOW_RST_03, `RIB_HIGH_RST_03, `RIB_XFER_RST_0306};
         default: {rst_low, rst_high, rst_xfer} =
            {`RIB_LOW_RST_06, `RIB_HIGH_RST_06, `RIB_XFER_RST_0306};
      endcase
   end

   assign addr_hit = (shift_r[7:1] == {`RIB_ADDR_HI, addr_option}); // R16

   // Data byte complete, taken on the falling edge that opens its ack
   assign wr_stb = (state_r == ST_RX) && scl_fall && (cnt_r == 4'd8) &&
                   (kind_r == K_DATA);

   ////////////////////////////////////////////////////////////////////////
   // Bus engine: sample on SCL rise, change SDA on SCL fall
   always @(posedge clk_sys) begin
      if (srst) begin
         state_r <= ST_IDLE;
         kind_r  <= K_ADDR;
         cnt_r   <= 4'd0;
         shift_r <= 8'h00;
         rw_r    <= 1'b0;
         nack_r  <= 1'b0;
         idx_r   <= 8'h00;
         sda_o   <= 1'b0;
         sda_oe  <= 1'b0;
      end else if (bus_start) begin
         // Repeated start keeps the index for the read that follows
         state_r <= ST_RX; // R17
         kind_r  <= K_ADDR;
         cnt_r   <= 4'd0;
         sda_oe  <= 1'b0;
      end else if (bus_stop) begin
         state_r <= ST_IDLE;
         sda_oe  <= 1'b0;
      end else begin
         case (state_r)
            ST_RX: begin
               if (scl_rise && cnt_r != 4'd8) begin
                  shift_r <= {shift_r[6:0], sda_i};
                  cnt_r   <= cnt_r + 4'd1;
               end else if (scl_fall && cnt_r == 4'd8) begin
                  if (kind_r == K_ADDR && !addr_hit) begin
                     // Foreign address: stay off the line
                     state_r <= ST_IDLE; // R2
                  end else begin
                     state_r <= ST_ACKO;
                     sda_oe  <= 1'b1; // R1
                     if (kind_r == K_ADDR) begin
                        rw_r <= shift_r[0];
                     end else if (kind_r == K_REG) begin
                        idx_r <= shift_r;
                     end else begin
                        idx_r <= idx_r + 8'h01;
                     end
                  end
               end
            end
            ST_ACKO: begin
               if (scl_fall) begin
                  cnt_r <= 4'd0;
                  if (kind_r == K_ADDR && rw_r) begin
                     state_r <= ST_TX;
                     shift_r <= rd_cur;
                     sda_oe  <= ~rd_cur[7];
                  end else begin
                     state_r <= ST_RX;
                     sda_oe  <= 1'b0;
                     kind_r  <= (kind_r == K_ADDR) ? K_REG : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_r <= cnt_r + 4'd1;
               end else if (scl_fall) begin
                  if (cnt_r == 4'd8) begin
                     state_r <= ST_ACKI;
                     sda_oe  <= 1'b0;
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     sda_oe  <= ~shift_r[6];
                  end
               end
            end
            ST_ACKI: begin
               if (scl_rise) begin
                  nack_r <= sda_i; // R2
               end else if (scl_fall) begin
                  cnt_r <= 4'd0;
                  if (nack_r) begin
                     state_r <= ST_IDLE;
                  end else begin
                     state_r <= ST_TX;
                     idx_r   <= idx_r + 8'h01;
                     shift_r <= rd_nxt;
                     sda_oe  <= ~rd_nxt[7];
                  end
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file
   always @(posedge clk_sys) begin
      if (srst) begin
         en_bit_r    <= rst_low[`RIB_EN_BIT]; // R15
         low_dac_r   <= rst_low[`RIB_DAC_MSB:0]; // R15
         high_dac_r  <= rst_high[`RIB_DAC_MSB:0]; // R15
         sw_dac_r    <= rst_high[`RIB_DAC_MSB:0];
         hw_sel_r    <= MODE_RST[`RIB_HW_BIT];
         mode_ovr_r  <= MODE_RST[`RIB_MCTL_MSB:`RIB_MCTL_LSB];
         hi_permit_r <= MODE_RST[`RIB_M1_BIT];
         lo_permit_r <= MODE_RST[`RIB_M0_BIT];
         go_r        <= rst_xfer[`RIB_GO_BIT];
         dis_r       <= rst_xfer[`RIB_DIS_BIT]; // R15
         slew_r      <= rst_xfer[`RIB_SLEW_MSB:0];
         xfer_start  <= 1'b0;
      end else begin
         xfer_start <= 1'b0;
         if (xfer_done) begin
            go_r <= 1'b0; // R18
         end
         if (wr_stb) begin
            case (idx_r)
               `RIB_IDX_LOW: begin
                  en_bit_r  <= shift_r[`RIB_EN_BIT]; // R5
                  low_dac_r <= shift_r[`RIB_DAC_MSB:0]; // R8
               end
               `RIB_IDX_HIGH: begin
                  en_bit_r   <= shift_r[`RIB_EN_BIT]; // R5
                  high_dac_r <= shift_r[`RIB_DAC_MSB:0]; // R8
               end
               `RIB_IDX_MODE: begin
                  // Vendor and reserved bits have no storage
                  hw_sel_r    <= shift_r[`RIB_HW_BIT]; // R9 R19
                  mode_ovr_r  <= shift_r[`RIB_MCTL_MSB:`RIB_MCTL_LSB];
                  hi_permit_r <= shift_r[`RIB_M1_BIT];
                  lo_permit_r <= shift_r[`RIB_M0_BIT]; // R3 R14
               end
               `RIB_IDX_XFER: begin
                  // Power-good is read-only; a write never lands there
                  dis_r  <= shift_r[`RIB_DIS_BIT]; // R4
                  slew_r <= shift_r[`RIB_SLEW_MSB:0];
                  if (shift_r[`RIB_GO_BIT]) begin
                     // Set beats a same-cycle completion
                     go_r <= 1'b1; // R18
                     if (!hw_sel_r) begin
                        sw_dac_r   <= high_dac_r; // R10
                        xfer_start <= 1'b1; // R10
                     end
                  end else begin
                     go_r <= 1'b0;
                  end
               end
               // No hold of the trigger here, so a completion still clears it
               default: xfer_start <= 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Regulator controls, registered one cycle after the policy
   always @(posedge clk_sys) begin
      if (srst) begin
         conv_run     <= 1'b0;
         dac_code     <= 6'h00;
         pfm_allow    <= 1'b0;
         discharge_en <= 1'b0;
         slew_code    <= 3'h0;
      end else begin
         conv_run     <= pol_run; // R6 R7
         dac_code     <= pol_code; // R8 R11
         pfm_allow    <= pol_pfm; // R12 R13
         discharge_en <= dis_r;
         slew_code    <= slew_r;
      end
   end

endmodule

`default_nettype wire

// *** design/rib_defs.vh ***
`ifndef RIB_DEFS_VH
`define RIB_DEFS_VH

// Register indices
`define RIB_IDX_LOW        8'h00
`define RIB_IDX_HIGH       8'h01
`define RIB_IDX_MODE       8'h02
`define RIB_IDX_XFER       8'h03

// Bus address, upper four bits fixed
`define RIB_ADDR_HI        4'h9

// Setpoint register fields
`define RIB_EN_BIT         7
`define RIB_SP_RSV_BIT     6
`define RIB_DAC_MSB        5

// Mode control fields
`define RIB_VID_MSB        7
`define RIB_VID_LSB        6
`define RIB_MC_RSV_BIT     5
`define RIB_HW_BIT         4
`define RIB_MCTL_MSB       3
`define RIB_MCTL_LSB       2
`define RIB_M1_BIT         1
`define RIB_M0_BIT         0

// Transition control fields
`define RIB_GO_BIT         7
`define RIB_DIS_BIT        6
`define RIB_PGOOD_BIT      5
`define RIB_SLEW_MSB       2

// Vendor code, value is arbitrary
`define RIB_VENDOR_ID      2'h1

// Reserved bit read values
`define RIB_SP_RSV_VAL     1'h1
`define RIB_MC_RSV_VAL     1'h1
`define RIB_XC_RSV_VAL     2'h0

// Mode override encodings
`define RIB_MCTL_PERBIT    2'h0
`define RIB_MCTL_FPWM      2'h2

// Factory option strap codes
`define RIB_OPT_00         2'h0
`define RIB_OPT_02         2'h1
`define RIB_OPT_03         2'h2
`define RIB_OPT_06         2'h3

// Reset values per option
`define RIB_LOW_RST_00     8'hD8
`define RIB_LOW_RST_02     8'hD0
`define RIB_LOW_RST_03     8'hD4
`define RIB_LOW_RST_06     8'hF1
`define RIB_HIGH_RST_00    8'hE4
`define RIB_HIGH_RST_02    8'hDC
`define RIB_HIGH_RST_03    8'hE4
`define RIB_HIGH_RST_06    8'hF1
`define RIB_MODE_RST       8'h90
`define RIB_XFER_RST_0002  8'h47
`define RIB_XFER_RST_0306  8'h07

`endif

// *** design/rib_cond.v ***
`timescale 1ns/1ps
`default_nettype none

module rib_cond (
   input  wire clk_sys,
   input  wire srst,
   input  wire scl_i,
   input  wire sda_i,
   output wire scl_rise,
   output wire scl_fall,
   output wire bus_start,
   output wire bus_stop
);

   reg scl_q_r;
   reg sda_q_r;

   // Idle bus is high; reset to that avoids a false edge
   always @(posedge clk_sys) begin
      if (srst) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl_i;
         sda_q_r <= sda_i;
      end
   end

   assign scl_rise  = scl_i & ~scl_q_r;
   assign scl_fall  = ~scl_i & scl_q_r;
   assign bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
   assign bus_stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;

endmodule

`default_nettype wire

// *** design/rib_policy.v ***
`timescale 1ns/1ps
`default_nettype none
`include "rib_defs.vh"

module rib_policy (
   input  wire       en_bit,
   input  wire       en_pin,
   input  wire       hw_sel,
   input  wire       sel_pin,
   input  wire [1:0] mode_ovr,
   input  wire       hi_permit,
   input  wire [5:0] low_code,
   input  wire [5:0] sw_code,
   input  wire [5:0] high_code,
   output wire       run,
   output wire [5:0] code,
   output wire       pfm
);

   wire on_high;

   // Bit off wins over the pin
   assign run = en_bit & en_pin; // R6 R7

   assign on_high = ~hw_sel | sel_pin; // R10 R11

   // Pin mode tracks either register live; software mode uses the latched code
   assign code = !hw_sel ? sw_code :
                 (sel_pin ? high_code : low_code); // R8 R10 R11

   // Low setpoint permits PFM unless the override forces PWM; its permit bit is never read
   assign pfm = (mode_ovr == `RIB_MCTL_FPWM)   ? 1'b0 :
                (mode_ovr != `RIB_MCTL_PERBIT) ? 1'b1 :
                (on_high ? hi_permit : 1'b1); // R12 R13 R14

endmodule

`default_nettype wire

// *** verif/rib_bank_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rib_bank_properties (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic       scl_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic       en_pin,
   input wire logic       setpoint_select_pin,
   input wire logic       conv_run,
   input wire logic [5:0] dac_code,
   input wire logic       pfm_allow,
   input wire logic       xfer_start
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   a_ack_drives_low: assert property (sda_oe |-> sda_o == 1'b0)
      else $error("data line driven high");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data line moved while clock high");
   a_shut_no_pin: assert property (!en_pin |=> !conv_run)
      else $error("converter runs with pin low");
   // Policy outputs move only on a bus write or a pin edge
   a_run_cause: assert property (!$past(srst) && !$past(srst, 2)
      && $changed(conv_run)
      |-> !scl_i || $past(en_pin) != $past(en_pin, 2))
      else $error("run changed without cause");
   a_code_cause: assert property (!$past(srst) && !$past(srst, 2)
      && $changed(dac_code)
      |-> !scl_i || $past(setpoint_select_pin)
          != $past(setpoint_select_pin, 2))
      else $error("code changed without cause");
   a_pfm_cause: assert property (!$past(srst) && !$past(srst, 2)
      && $changed(pfm_allow)
      |-> !scl_i || $past(setpoint_select_pin)
          != $past(setpoint_select_pin, 2))
      else $error("mode changed without cause");
   a_go_pulse: assert property (xfer_start |=> !xfer_start)
      else $error("trigger pulse too long");
   a_go_on_write: assert property ($rose(xfer_start) |-> !scl_i)
      else $error("trigger without bus write");
endmodule
`default_nettype wire

// *** verif/rib_i2c_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module rib_i2c_master (
   input  wire logic clk_sys,
   input  wire logic sda_w,
   output var  logic scl,
   output var  logic sda_m
);
   // Data released means the pull-up wins
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Four cycles per level keeps the two-sample edge detect safe
   task automatic half();
      repeat (4) @(negedge clk_sys);
   endtask
   // Also a repeated start when entered with the clock low
   task automatic start();
      sda_m = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_m = 1'b0;
      half();
      scl = 1'b0;
      half();
   endtask
   task automatic stop();
      sda_m = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_m = 1'b1;
      half();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      half();
      scl = 1'b1;
      half();
      r = sda_w;
      scl = 1'b0;
      half();
   endtask
   // MSB first; a_in is driven in the ninth slot
   task automatic byte_io(input logic [7:0] d, input logic a_in,
                          output logic [7:0] q, output logic a_out);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(a_in, a_out);
   endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rib_defs.vh"
module tb_top;
   logic       clk_sys = 1'b0;
   logic       srst = 1'b1;
   logic       en_pin = 1'b1;
   logic       sel_pin = 1'b0;
   logic [1:0] option_sel = 2'h0;
   logic       power_good = 1'b1;
   logic       xfer_done = 1'b0;
   wire        scl_w, sda_m, sda_o, sda_oe, conv_run, pfm_allow;
   wire        discharge_en, xfer_start;
   wire  [5:0] dac_code;
   wire  [2:0] slew_code;
   wire        sda_w = sda_oe ? 1'b0 : sda_m;
   int         err_count = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         n_go = 0;
   localparam logic [2:0] AOPT = 3'h5;
   logic [7:0] lo_t [4] = '{8'hD8, 8'hD0, 8'hD4, 8'hF1};
   logic [7:0] hi_t [4] = '{8'hE4, 8'hDC, 8'hE4, 8'hF1};
   logic [7:0] q, ex;
   logic       a;

   always #50 clk_sys = ~clk_sys;

   // Trigger pulses, counted away from the edge that launches them
   always @(negedge clk_sys) begin
      if (xfer_start === 1'b1)
         n_go++;
   end

   rib_bank rib_bank_i (
      .clk_sys(clk_sys), .srst(srst), .scl_i(scl_w), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe(sda_oe), .en_pin(en_pin),
      .setpoint_select_pin(sel_pin), .option_sel(option_sel),
      .addr_option(AOPT), .power_good(power_good),
      .xfer_done(xfer_done), .conv_run(conv_run), .dac_code(dac_code),
      .pfm_allow(pfm_allow), .discharge_en(discharge_en),
      .slew_code(slew_code), .xfer_start(xfer_start));
   rib_i2c_master rib_i2c_master_i (
      .clk_sys(clk_sys), .sda_w(sda_w), .scl(scl_w), .sda_m(sda_m));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] b [3];
      logic [7:0] x;
      logic       ak;
      b = '{{`RIB_ADDR_HI, AOPT, 1'b0}, idx, d};
      rib_i2c_master_i.start();
      for (int i = 0; i < 3; i++) begin
         rib_i2c_master_i.byte_io(b[i], 1'b1, x, ak);
         chk(8'(ak), 8'h00);
      end
      rib_i2c_master_i.stop();
   endtask
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      logic ak;
      rib_i2c_master_i.start();
      rib_i2c_master_i.byte_io({`RIB_ADDR_HI, AOPT, 1'b0}, 1'b1, d, ak);
      rib_i2c_master_i.byte_io(idx, 1'b1, d, ak);
      rib_i2c_master_i.start();
      rib_i2c_master_i.byte_io({`RIB_ADDR_HI, AOPT, 1'b1}, 1'b1, d, ak);
      chk(8'(ak), 8'h00);
      rib_i2c_master_i.byte_io(8'hFF, 1'b1, d, ak);
      rib_i2c_master_i.stop();
   endtask
   task automatic results();
      $display("errors %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Whole run is near 25k cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 80000) begin
         err_count++;
         results();
      end
   end

   initial begin
      for (int o = 0; o < 4; o++) begin
         @(negedge clk_sys);
         srst = 1'b1;
         option_sel = o[1:0];
         repeat (20) @(negedge clk_sys);
         srst = 1'b0;
         repeat (2) @(negedge clk_sys);
         rd(`RIB_IDX_LOW, q);
         chk(q, lo_t[o]);
         rd(`RIB_IDX_HIGH, q);
         chk(q, hi_t[o]);
         rd(`RIB_IDX_MODE, q);
         chk(q, {`RIB_VENDOR_ID, `RIB_MC_RSV_VAL, 5'h10});
         rd(`RIB_IDX_XFER, q);
         chk(q, {1'b0, o < 2, power_good, 5'h07});
         chk({2'h0, dac_code}, lo_t[o] & 8'h3F);
         chk({4'h0, discharge_en, slew_code}, {4'h0, o < 2, 3'h7});
         chk(8'(conv_run), 8'h01);
      end
      wr(`RIB_IDX_LOW, 8'h15);
      rd(`RIB_IDX_HIGH, q);
      chk(q, 8'h71);
      chk(8'(conv_run), 8'h00);
      wr(`RIB_IDX_HIGH, 8'hAA);
      rd(`RIB_IDX_LOW, q);
      chk(q, 8'hD5);
      rd(`RIB_IDX_HIGH, q);
      chk(q, 8'hEA);
      chk(8'(conv_run), 8'h01);
      en_pin = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(8'(conv_run), 8'h00);
      en_pin = 1'b1;
      sel_pin = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk({2'h0, dac_code}, 8'h2A);
      sel_pin = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk({2'h0, dac_code}, 8'h15);
      // Low permit bit always opposite to the high one
      for (int i = 0; i < 16; i++) begin
         ex = {~`RIB_VENDOR_ID, 1'b0, i[3], i[1:0], i[2], ~i[2]};
         wr(`RIB_IDX_MODE, ex);
         rd(`RIB_IDX_MODE, q);
         chk(q, {`RIB_VENDOR_ID, `RIB_MC_RSV_VAL, ex[4:0]});
         chk(8'(pfm_allow), 8'((i[1:0] == 2) ? 0
            : (i[1:0] != 0 || i[3]) ? 1 : i[2]));
      end
      wr(`RIB_IDX_MODE, 8'h00);
      chk({2'h0, dac_code}, 8'h31);
      wr(`RIB_IDX_XFER, 8'hC3);
      chk({2'h0, dac_code}, 8'h2A);
      chk(8'(n_go), 8'h01);
      rd(`RIB_IDX_XFER, q);
      chk(q, 8'hE3);
      xfer_done = 1'b1;
      @(negedge clk_sys);
      xfer_done = 1'b0;
      power_good = 1'b0;
      rd(`RIB_IDX_XFER, q);
      chk(q, 8'h43);
      rib_i2c_master_i.start();
      rib_i2c_master_i.byte_io({`RIB_ADDR_HI, ~AOPT, 1'b0}, 1'b1, q, a);
      chk(8'(a), 8'h01);
      rib_i2c_master_i.stop();
      rd(8'h07, q);
      chk(q, 8'h00);
      results();
   end
endmodule

bind rib_bank rib_bank_properties rib_bank_properties_i (
   .clk_sys(clk_sys), .srst(srst), .scl_i(scl_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .en_pin(en_pin),
   .setpoint_select_pin(setpoint_select_pin), .conv_run(conv_run),
   .dac_code(dac_code), .pfm_allow(pfm_allow), .xfer_start(xfer_start));
`default_nettype wire
